// ### hdl/csspi_pkg.sv
// csspi_pkg: register map, field positions and reset values of the clocked serial port.
// assumes an APB master with 32-bit data; registers sit at index*4.
package csspi_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_DATA   = 8'hD0;
	localparam logic [7:0] IDX_STATUS = 8'hD3;
	localparam logic [7:0] IDX_CTRL   = 8'hD4;
	localparam logic [7:0] IDX_RATE   = 8'hD5;
	localparam logic [7:0] IDX_SELECT = 8'hD6;

	localparam int ADDR_W       = 12;
	localparam int IDX_LSB      = 2;
	localparam int IDX_MSB      = 9;

	// control fields
	localparam int CMD_TX_BIT   = 7;
	localparam int CMD_RX_BIT   = 6;
	localparam int SRC_MSB      = 5;
	localparam int SRC_LSB      = 4;
	localparam int MODE_MSB     = 3;
	localparam int MODE_LSB     = 2;
	localparam int PRIO_MSB     = 1;
	localparam int PRIO_LSB     = 0;
	localparam logic [1:0] SRC_FIRST   = 2'h0;
	localparam logic [1:0] SRC_ALT     = 2'h1;
	localparam logic [1:0] MODE_EXTCLK = 2'h2;
	localparam logic [1:0] MODE_INTCLK = 2'h3;
	localparam logic [1:0] PRIO_OFF    = 2'h0;

	// status fields
	localparam int ST_RX_FULL   = 7;
	localparam int ST_RX_ADDR   = 6;
	localparam int ST_OVERRUN   = 5;
	localparam int ST_TX_FULL   = 3;
	localparam int ST_TX_BUSY   = 2;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h07;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// longest wait, in clocks, from loading a master byte to its last falling edge
	localparam logic [12:0] TX_WAIT_MAX = 13'h1068;

	typedef enum logic [1:0] {
		CSSPI_RX_IDLE  = 2'b00,
		CSSPI_RX_SHIFT = 2'b01
	} csspi_rx_state_type;
endpackage : csspi_pkg

// ### hdl/csspi_port.sv
// csspi_port: clocked serial port acting as a byte-wide serial master (or clocked slave),
// with one-byte transmit and receive buffers and a shared interrupt request.
// assumes an APB master on clk_i; serial pins are asynchronous and are synchronised here.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module csspi_port import csspi_pkg::*; (
	input  wire logic              clk_i,        // system clock, 10 MHz
	input  wire logic              rst_b_i,      // async reset, active low
	input  wire logic              psel_i,       // apb select
	input  wire logic              penable_i,    // apb enable
	input  wire logic              pwrite_i,     // apb direction
	input  wire logic [ADDR_W-1:0] paddr_i,      // apb byte address
	input  wire logic [31:0]       pwdata_i,     // apb write data
	output logic      [31:0]       prdata_o,     // apb read data
	output logic                   pready_o,     // apb ready
	output logic                   pslverr_o,    // apb error, unmapped address
	input  wire logic              sck_i,        // serial clock pin level
	output logic                   sck_o,        // serial clock drive value
	output logic                   sck_oe_o,     // serial clock drive enable
	output logic                   txd_o,        // serial data out
	input  wire logic              rxd_first_i,  // serial data in, first port
	input  wire logic              rxd_alt_i,    // serial data in, alternate port
	output logic                   peripheral_select_n_o, // slave select, low active
	output logic                   irq_o,        // shared interrupt request
	output logic      [1:0]        irq_prio_o    // interrupt priority, 0 = off
);

	////////////////////////////////////////////////////////////////////////////////
	// registers and shared wires
	logic [7:0]         ctrl_reg, rate_reg, half_cnt_reg;
	logic               sck_reg, sck_s1_reg, sck_s2_reg, sck_s3_reg;
	logic               rxa_s1_reg, rxa_s2_reg, rxb_s1_reg, rxb_s2_reg;
	logic [7:0]         tx_buf_reg, tx_shift_reg;
	logic [3:0]         tx_cnt_reg;
	logic               tx_full_reg, tx_busy_reg, tx_pend_reg, tx_irq_reg, txd_reg;
	csspi_rx_state_type rx_state_reg;
	logic [7:0]         rx_shift_reg, rx_buf_reg;
	logic [3:0]         rx_cnt_reg;
	logic               rx_full_reg, overrun_reg, sel_n_reg;
	logic               pready_reg, pslverr_reg, irq_reg;
	logic [31:0]        prdata_reg;
	logic [12:0]        tx_wait_reg;

	logic [7:0] idx;
	logic       mapped;
	logic       acc_wr, acc_rd;
	logic       ctrl_wr, data_wr, status_wr, data_rd;
	logic       clocked, master;
	logic       tx_cmd, rx_cmd;
	logic       run, half_tick, fall_ev, rise_ev;
	logic       tx_end, tx_free, tx_load;
	logic       rx_busy, rx_done, rx_bit;
	logic [7:0] status_val;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode; one cycle of setup, zero wait states in access
	assign idx    = paddr_i[IDX_MSB:IDX_LSB];
	assign mapped = (paddr_i[ADDR_W-1:IDX_MSB+1] == '0) && (paddr_i[IDX_LSB-1:0] == '0) &&
	                (idx == IDX_DATA || idx == IDX_STATUS || idx == IDX_CTRL ||
	                 idx == IDX_RATE || idx == IDX_SELECT);
	assign acc_wr    = psel_i && penable_i && pready_reg && pwrite_i && mapped;
	assign acc_rd    = psel_i && penable_i && pready_reg && !pwrite_i && mapped;
	assign ctrl_wr   = acc_wr && idx == IDX_CTRL;
	assign data_wr   = acc_wr && idx == IDX_DATA;
	assign status_wr = acc_wr && idx == IDX_STATUS;
	assign data_rd   = acc_rd && idx == IDX_DATA;

	assign clocked = ctrl_reg[MODE_MSB];
	assign master  = ctrl_reg[MODE_MSB:MODE_LSB] == MODE_INTCLK;
	// commands are decoded from the written word; only a waiting transmit command is stored, in tx_pend_reg
	assign tx_cmd  = ctrl_wr && clocked && pwdata_i[CMD_TX_BIT];
	assign rx_cmd  = ctrl_wr && clocked && pwdata_i[CMD_RX_BIT];

	// clocked mode never carries address bytes, so bit 6 always reads data
	assign status_val = {rx_full_reg, 1'b0, overrun_reg, 1'b0,
	                     tx_full_reg, tx_busy_reg, 2'b00};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= psel_i && !penable_i;
			pslverr_reg <= psel_i && !penable_i && !mapped;
			if (psel_i && !penable_i) begin
				prdata_reg <= 32'h00000000;
				if (!pwrite_i) begin
					unique case (idx)
						IDX_DATA:   prdata_reg[7:0] <= rx_buf_reg;
						IDX_STATUS: prdata_reg[7:0] <= status_val;
						IDX_CTRL:   prdata_reg[7:0] <= ctrl_reg;
						IDX_RATE:   prdata_reg[7:0] <= rate_reg;
						IDX_SELECT: prdata_reg[0]   <= sel_n_reg;
						default:    prdata_reg      <= 32'h00000000;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_reg  <= CTRL_RESET;
			rate_reg  <= RATE_RESET;
			sel_n_reg <= 1'b1;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg <= {2'b00, pwdata_i[SRC_MSB:0]};
			end
			if (acc_wr && idx == IDX_RATE) begin
				rate_reg <= pwdata_i[7:0];
			end
			if (acc_wr && idx == IDX_SELECT) begin
				sel_n_reg <= pwdata_i[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; logic reads the second stage, and the clock edge detect also reads the third
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sck_s1_reg <= 1'b1;
			sck_s2_reg <= 1'b1;
			sck_s3_reg <= 1'b1;
			rxa_s1_reg <= 1'b1;
			rxa_s2_reg <= 1'b1;
			rxb_s1_reg <= 1'b1;
			rxb_s2_reg <= 1'b1;
		end else begin
			sck_s1_reg <= sck_i;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
			rxa_s1_reg <= rxd_first_i;
			rxa_s2_reg <= rxa_s1_reg;
			rxb_s1_reg <= rxd_alt_i;
			rxb_s2_reg <= rxb_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bit clock: half_tick every rate+1 cycles, so one bit is 2*(rate+1) clocks
	assign run       = master && (tx_busy_reg || rx_busy);
	assign half_tick = run && half_cnt_reg == rate_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			half_cnt_reg <= 8'h00;
			sck_reg      <= 1'b1;
		end else if (!run) begin
			// idle high so the first edge of a byte is always a falling one
			half_cnt_reg <= 8'h00;
			sck_reg      <= 1'b1;
		end else if (half_tick) begin
			half_cnt_reg <= 8'h00;
			sck_reg      <= !sck_reg;
		end else begin
			half_cnt_reg <= half_cnt_reg + 8'h01;
		end
	end

	// external clock edges come from the synchronised pin, two cycles late
	assign fall_ev = master ? (half_tick && sck_reg)  : (clocked && sck_s3_reg && !sck_s2_reg);
	assign rise_ev = master ? (half_tick && !sck_reg) : (clocked && !sck_s3_reg && sck_s2_reg);

	////////////////////////////////////////////////////////////////////////////////
	// transmitter
	assign tx_end  = tx_busy_reg && rise_ev && tx_cnt_reg == BITS_PER_BYTE;
	assign tx_free = !tx_busy_reg || tx_end;
	// a command seen while busy or with an empty buffer waits until the shifter is free and the buffer is full
	assign tx_load = tx_free && (tx_cmd || tx_pend_reg) && tx_full_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_buf_reg  <= 8'h00;
			tx_full_reg <= 1'b0;
			tx_pend_reg <= 1'b0;
		end else begin
			// a write in the loading cycle queues behind the byte being taken
			if (data_wr) begin
				tx_buf_reg  <= pwdata_i[7:0];
				tx_full_reg <= 1'b1;
			end else if (tx_load) begin
				tx_full_reg <= 1'b0;
			end
			if (tx_load) begin
				tx_pend_reg <= 1'b0;
			end else if (tx_cmd) begin
				tx_pend_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 8'h00;
			tx_cnt_reg   <= 4'h0;
			txd_reg      <= 1'b1;
		end else if (tx_load) begin
			tx_busy_reg  <= 1'b1;
			tx_shift_reg <= tx_buf_reg;
			tx_cnt_reg   <= 4'h0;
		end else if (tx_end) begin
			tx_busy_reg  <= 1'b0;
		end else if (tx_busy_reg && fall_ev && tx_cnt_reg != BITS_PER_BYTE) begin
			txd_reg      <= tx_shift_reg[0];
			tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
			tx_cnt_reg   <= tx_cnt_reg + 4'h1;
		end
	end

	// set wins over the clearing write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_irq_reg <= 1'b0;
		end else if (tx_load || (tx_end && !tx_full_reg)) begin
			tx_irq_reg <= 1'b1;
		end else if (data_wr || status_wr) begin
			tx_irq_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receiver
	assign rx_busy = rx_state_reg == CSSPI_RX_SHIFT;
	assign rx_done = rx_busy && rise_ev && rx_cnt_reg == BITS_PER_BYTE - 4'h1;
	always_comb begin
		unique case (ctrl_reg[SRC_MSB:SRC_LSB])
			SRC_FIRST: rx_bit = rxa_s2_reg;
			SRC_ALT:   rx_bit = rxb_s2_reg;
			default:   rx_bit = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_state_reg <= CSSPI_RX_IDLE;
			rx_shift_reg <= 8'h00;
			rx_cnt_reg   <= 4'h0;
		end else begin
			unique case (rx_state_reg)
				CSSPI_RX_IDLE: begin
					if (rx_cmd) begin
						rx_state_reg <= CSSPI_RX_SHIFT;
						rx_cnt_reg   <= 4'h0;
					end
				end
				CSSPI_RX_SHIFT: begin
					if (rise_ev) begin
						rx_shift_reg <= {rx_bit, rx_shift_reg[7:1]};
						rx_cnt_reg   <= rx_cnt_reg + 4'h1;
						if (rx_done) begin
							rx_state_reg <= CSSPI_RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_buf_reg  <= 8'h00;
			rx_full_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else if (rx_done) begin
			rx_buf_reg  <= {rx_bit, rx_shift_reg[7:1]};
			rx_full_reg <= 1'b1;
			if (rx_full_reg && !data_rd) begin
				overrun_reg <= 1'b1;
			end else if (data_rd) begin
				overrun_reg <= 1'b0;
			end
		end else if (data_rd) begin
			rx_full_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared interrupt, gated by the priority field
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (ctrl_reg[PRIO_MSB:PRIO_LSB] != PRIO_OFF) &&
			           (rx_full_reg || tx_irq_reg);
		end
	end

	assign prdata_o   = prdata_reg;
	assign pready_o   = pready_reg;
	assign pslverr_o  = pslverr_reg;
	assign sck_o      = sck_reg;
	assign sck_oe_o   = master;
	assign txd_o      = txd_reg;
	assign peripheral_select_n_o = sel_n_reg;
	assign irq_o      = irq_reg;
	assign irq_prio_o = ctrl_reg[PRIO_MSB:PRIO_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// clocks a master byte has waited for its last falling edge; external clock may stall
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_wait_reg <= 13'h0000;
		end else if (tx_load) begin
			tx_wait_reg <= 13'h0000;
		end else if (tx_busy_reg && master && tx_cnt_reg != BITS_PER_BYTE) begin
			tx_wait_reg <= tx_wait_reg + 13'h0001;
		end
	end

	chk_no_early_shift: assert property ($rose(tx_busy_reg) |-> $past(tx_cmd || tx_pend_reg))
		else $error("transmitter started without a command");
	chk_tx_cmd_start: assert property (tx_cmd && !tx_busy_reg && tx_full_reg |=> tx_busy_reg && !tx_full_reg)
		else $error("transmit command did not start shifting");
	chk_rx_cmd_start: assert property (rx_cmd && !rx_busy |=> rx_busy)
		else $error("receive command did not start receiver");
	chk_txd_on_fall: assert property ($changed(txd_reg) |-> $past(fall_ev))
		else $error("serial data changed away from falling edge");
	chk_duplex_start: assert property (tx_cmd && rx_cmd && !tx_busy_reg && tx_full_reg && !rx_busy |=> tx_busy_reg && rx_busy)
		else $error("combined command did not start both");
	chk_rx_fill: assert property (rx_done |=> rx_full_reg ##1 (irq_reg || ctrl_reg[1:0] == PRIO_OFF))
		else $error("received byte did not fill buffer and request");
	chk_overrun_set: assert property (rx_done && rx_full_reg && !data_rd |=> overrun_reg)
		else $error("overrun not flagged");
	chk_read_clears: assert property (data_rd && !rx_done |=> !rx_full_reg && !overrun_reg)
		else $error("buffer read did not clear flags");
	chk_zero_bits: assert property (pready_reg && !pwrite_i && idx == IDX_STATUS |-> prdata_reg[4] == 1'b0 && prdata_reg[1:0] == 2'b00)
		else $error("reserved status bits not zero");
	chk_load_irq: assert property (tx_load |=> tx_irq_reg && !tx_full_reg)
		else $error("buffer move did not raise transmit request");
	chk_irq_gated: assert property (ctrl_reg[1:0] == PRIO_OFF |=> !irq_reg)
		else $error("interrupt raised while disabled");
	chk_byte_length: assert property (tx_wait_reg < TX_WAIT_MAX)
		else $error("transmit byte did not complete in time");

endmodule : csspi_port
`default_nettype wire

// ### testbench/csspi_slave_model.sv
// csspi_slave_model: serial slave standing on the far side of the port.
// assumes the clock idles high; data changes on falling and is taken on rising edges.
`timescale 1ns/1ps
`default_nettype none
module csspi_slave_model (
	input  wire logic       sck_i,   // serial clock as seen on the wire
	input  wire logic       mosi_i,  // data from the port
	input  wire logic       sel_n_i, // select, low active
	input  wire logic [7:0] load_i,  // byte returned in the next frame
	output logic            miso_o,  // data to the port
	output logic      [7:0] got_o    // last byte shifted in
);
	logic [7:0] out_reg;
	logic       sel_q;
	logic       sck_q;

	////////////////////////////////////////////////////////////////////////////////
	// one process owns every output; edges are found against the last seen levels
	initial begin
		miso_o  = 1'b1;
		got_o   = 8'h00;
		out_reg = 8'h00;
		sel_q   = 1'b1;
		sck_q   = 1'b1;
		forever begin
			@(sel_n_i or sck_i);
			// a fresh frame starts on each select fall
			if (sel_q === 1'b1 && sel_n_i === 1'b0) begin
				out_reg = load_i;
			end
			// released line must not keep showing the last bit
			if (sel_q === 1'b0 && sel_n_i === 1'b1) begin
				miso_o = ~miso_o;
			end
			if (sel_n_i === 1'b0 && sck_q === 1'b1 && sck_i === 1'b0) begin
				miso_o  = out_reg[0];
				out_reg = {1'b0, out_reg[7:1]};
			end
			if (sel_n_i === 1'b0 && sck_q === 1'b0 && sck_i === 1'b1) begin
				got_o = {mosi_i, got_o[7:1]};
			end
			sel_q = sel_n_i;
			sck_q = sck_i;
		end
	end
endmodule : csspi_slave_model
`default_nettype wire

// ### testbench/csspi_port_tb_top.sv
// csspi_port_tb_top: self-checking bench for the clocked serial port.
// assumes the port answers apb in its own time; the wire clock comes from ext_sck when the port does not drive it.
`timescale 1ns/1ps
`default_nettype none
module csspi_port_tb_top import csspi_pkg::*;;
	typedef struct {
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wd;
		logic [31:0] rd;
		logic        err;
	} csspi_row_type;

	localparam logic [11:0] A_DATA = {2'b00, IDX_DATA, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, IDX_STATUS, 2'b00};
	localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
	localparam logic [11:0] A_RATE = {2'b00, IDX_RATE, 2'b00};
	localparam logic [11:0] A_SEL  = {2'b00, IDX_SELECT, 2'b00};

	logic        clk_i, rst_b_i, psel, penable, pwrite, ext_sck;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_o;
	logic        pready_o, pslverr_o, sck_o, sck_oe_o, txd_o, sel_n, irq_o, miso;
	logic [1:0]  irq_prio_o;
	logic [7:0]  slave_load, slave_got;
	wire         sck_line;
	int          fails, cmp_count;

	assign sck_line = sck_oe_o ? sck_o : ext_sck;

	csspi_port csspi_port_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sck_i(sck_line),
		.sck_o(sck_o), .sck_oe_o(sck_oe_o), .txd_o(txd_o), .rxd_first_i(miso),
		.rxd_alt_i(~miso), .peripheral_select_n_o(sel_n), .irq_o(irq_o),
		.irq_prio_o(irq_prio_o));

	csspi_slave_model csspi_slave_model_i (.sck_i(sck_line), .mosi_i(txd_o),
		.sel_n_i(sel_n), .load_i(slave_load), .miso_o(miso), .got_o(slave_got));

	csspi_row_type rows [9] = '{
		'{1'b0, A_STAT, 32'h0, 32'h00, 1'b0}, '{1'b0, A_CTRL, 32'h0, {24'h0, CTRL_RESET}, 1'b0},
		'{1'b0, A_RATE, 32'h0, {24'h0, RATE_RESET}, 1'b0}, '{1'b1, A_CTRL, 32'h0D, 32'h0, 1'b0},
		'{1'b0, A_CTRL, 32'h0, 32'h0D, 1'b0}, '{1'b0, 12'h000, 32'h0, 32'h0, 1'b1},
		'{1'b1, 12'h004, 32'hFF, 32'h0, 1'b1}, '{1'b1, A_DATA, 32'hA5, 32'h0, 1'b0},
		'{1'b0, A_STAT, 32'h0, 32'h08, 1'b0}};

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp);
	endtask : rdchk

	task automatic settle(input int n);
		repeat (n) @(negedge clk_i);
	endtask : settle

	// one byte frame; polls status until a bit of mask shows
	task automatic run_byte(input logic [7:0] tx, input logic [7:0] sb, input logic [7:0] c1,
			input logic [7:0] c2, input logic [7:0] mask);
		logic [31:0] r;
		logic        e;
		slave_load = sb;
		wr(A_SEL, 32'h1);
		wr(A_SEL, 32'h0);
		if (c1[7]) wr(A_DATA, {24'h0, tx});
		wr(A_CTRL, {24'h0, c1});
		if (c2 != 8'h00) wr(A_CTRL, {24'h0, c2});
		if (c1[7]) begin
			rdchk(A_STAT, 32'h04);
			check({31'h0, irq_o}, 32'h1);
			wr(A_STAT, 32'h0);
			settle(2);
			check({31'h0, irq_o}, 32'h0);
		end
		do apb(1'b0, A_STAT, 32'h0, r, e); while ((r[7:0] & mask) == 8'h00);
		settle(20);
	endtask : run_byte

	task automatic results();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	// a full run is about a thousand cycles; this leaves some thirty times that
	initial begin
		#3000000;
		fails++;
		results();
	end

	initial begin
		logic [31:0] r;
		logic        e;
		rst_b_i = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_sck = 1'b1;
		slave_load = 8'h00;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].wd, r, e);
			if (!rows[i].wr) check(r, rows[i].rd);
			check({31'h0, e}, {31'h0, rows[i].err});
		end
		settle(40);
		check({31'h0, txd_o}, 32'h1);
		check({31'h0, sck_o}, 32'h1);
		$display("register table test done");

		run_byte(8'hA5, 8'h3C, 8'hCD, 8'h00, 8'h80);
		rdchk(A_STAT, 32'h80);
		check({31'h0, irq_o}, 32'h1);
		check({24'h0, slave_got}, 32'hA5);
		rdchk(A_DATA, 32'h3C);
		rdchk(A_STAT, 32'h00);
		check({31'h0, irq_o}, 32'h1);
		for (int p = 0; p < 4; p++) begin
			wr(A_CTRL, 32'h0C | 32'(p));
			settle(2);
			check({30'h0, irq_prio_o}, 32'(p));
			check({31'h0, irq_o}, {31'h0, p != 0});
			check({31'h0, sck_oe_o}, 32'h1);
		end
		wr(A_STAT, 32'h0);
		settle(2);
		check({31'h0, irq_o}, 32'h0);
		$display("single write duplex test done");

		run_byte(8'h5A, 8'h81, 8'h8D, 8'h4D, 8'h80);
		check({24'h0, slave_got}, 32'h5A);
		rdchk(A_DATA, 32'h81);
		$display("two write duplex test done");

		run_byte(8'h00, 8'h0F, 8'h4D, 8'h00, 8'h80);
		run_byte(8'h00, 8'h96, 8'h5D, 8'h00, 8'h20);
		rdchk(A_STAT, 32'hA0);
		rdchk(A_DATA, 32'h69);
		rdchk(A_STAT, 32'h00);
		$display("overrun and source test done");

		wr(A_CTRL, 32'h09);
		settle(2);
		check({31'h0, sck_oe_o}, 32'h0);
		fork
			run_byte(8'h3C, 8'hC3, 8'hC9, 8'h00, 8'h80);
			begin
				// wire clock starts once both commands have been taken
				repeat (51) @(posedge clk_i);
				repeat (8) begin
					ext_sck <= 1'b0;
					repeat (4) @(posedge clk_i);
					ext_sck <= 1'b1;
					repeat (4) @(posedge clk_i);
				end
			end
		join
		check({24'h0, slave_got}, 32'h3C);
		rdchk(A_DATA, 32'hC3);
		$display("external clock test done");

		@(posedge clk_i);
		rst_b_i <= 1'b0;
		settle(2);
		check({28'h0, sel_n, txd_o, irq_o, sck_oe_o}, 32'hC);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		rdchk(A_CTRL, {24'h0, CTRL_RESET});
		rdchk(A_RATE, {24'h0, RATE_RESET});
		rdchk(A_STAT, 32'h00);
		$display("reset test done");
		results();
	end
endmodule : csspi_port_tb_top
`default_nettype wire
